/* File: core/oam_decoder.sv */
/*
 Operand address decoder: turns a pre-split instruction into effective
 addresses, literal operands and X/Y address unit requests, and writes
 modified pointers back to the working registers.
 Assumes the instruction stream offers one instruction at a time under
 ready, and the address units take a request in the cycle it shows.
*/
// How it works
// - Move and accumulator classes also accept register-offset indexed mode.
// - Move source and destination modes are decoded independently.
// - One 4-bit offset register field serves both move operands.
// - Move/accumulator: direct, indirect, post, pre, indexed, offset, literals.
// - Registers eight, nine go to X unit; ten, eleven to Y unit.
// - Dual-operand indexed mode only for register nine and eleven.
// - Dual-operand modes: indirect, post-modify by 2, 4, 6, indexed.
// - All eight dual-operand instructions use only the reduced set.
// - Branch target comes from a 16-bit signed literal in the word.
// - Interrupt-disable takes a 14-bit unsigned literal operand.
// - Frame unlink operands come from the opcode; no-op has none.
`timescale 1ns/1ps
`include "oam_map.svh"
module oam_decoder
	import oam_pkg::*;
#(
	parameter int DW = 16,
	parameter int AW = 4
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire oam_instr_t instr,
	input wire oam_wreq_t wrReq,
	output logic ready,
	output oam_result_t result
);
	oam_state_t state_r, state_nxt;
	oam_instr_t instr_r, instr_nxt;
	oam_result_t result_r, result_nxt;
	logic ready_r, ready_nxt;
	logic [AW-1:0] rdAddrA, rdAddrB, rdAddrC;
	logic [DW-1:0] baseA, baseB, offVal;
	logic wrEnA, wrEnB;
	logic [AW-1:0] wrAddrA, wrAddrB;
	logic [DW-1:0] wrDataA, wrDataB;
	logic accept;

	// True for the dual source operand group
	function automatic logic isDual(input oam_class_t c);
		unique case (c)
			OAM_C_ACC_CLEAR, OAM_C_EUCLID, OAM_C_DIST_ACCUM, OAM_C_MULT_ACCUM,
			OAM_C_MULTIPLY, OAM_C_NEG_MULTIPLY, OAM_C_STORE_ACC,
			OAM_C_MULT_SUB: isDual = 1'b1;
			default: isDual = 1'b0;
		endcase
	endfunction : isDual

	// Operand of a move or accumulator mode
	function automatic oam_operand_t operandOf(input oam_mode_t m,
			input logic [3:0] r, input logic [15:0] base,
			input logic [15:0] off, input logic [15:0] lit);
		oam_operand_t o;
		o = '0;
		o.regIdx = r;
		unique case (m)
			OAM_M_REG_DIRECT: begin
				o.isReg = 1'b1;
				o.value = base;
			end
			OAM_M_INDIRECT, OAM_M_POST_INC, OAM_M_POST_DEC: begin
				o.used = 1'b1;
				o.value = base;
			end
			OAM_M_PRE_INC: begin
				o.used = 1'b1;
				o.value = base + `OAM_WORD_STEP;
			end
			OAM_M_PRE_DEC: begin
				o.used = 1'b1;
				o.value = base - `OAM_WORD_STEP;
			end
			OAM_M_INDEXED: begin
				o.used = 1'b1;
				o.value = base + off;
			end
			OAM_M_LIT_OFFSET: begin
				o.used = 1'b1;
				o.value = base + lit;
			end
			OAM_M_LIT8: begin
				o.isLit = 1'b1;
				o.value = {{(16-`OAM_LIT8_W){1'b0}}, lit[`OAM_LIT8_W-1:0]};
			end
			OAM_M_LIT16: begin
				o.isLit = 1'b1;
				o.value = lit;
			end
			default: o = '0;
		endcase
		return o;
	endfunction : operandOf

	// Pointer value after a pre or post modification
	function automatic logic [15:0] pointerNext(input oam_mode_t m,
			input logic [15:0] base);
		unique case (m)
			OAM_M_POST_INC, OAM_M_PRE_INC: pointerNext = base + `OAM_WORD_STEP;
			OAM_M_POST_DEC, OAM_M_PRE_DEC: pointerNext = base - `OAM_WORD_STEP;
			default: pointerNext = base; // Indexed leaves base alone
		endcase
	endfunction : pointerNext

	function automatic logic modifies(input oam_mode_t m);
		modifies = (m == OAM_M_POST_INC) || (m == OAM_M_POST_DEC) ||
			(m == OAM_M_PRE_INC) || (m == OAM_M_PRE_DEC);
	endfunction : modifies

	// Post-modify step of a dual-operand pointer
	function automatic logic [15:0] dualStep(input oam_dual_mode_t m);
		unique case (m)
			OAM_D_POST2: dualStep = `OAM_DUAL_STEP2;
			OAM_D_POST4: dualStep = `OAM_DUAL_STEP4;
			OAM_D_POST6: dualStep = `OAM_DUAL_STEP6;
			default: dualStep = `OAM_NO_STEP;
		endcase
	endfunction : dualStep

	// Address unit request of one prefetch pointer
	function automatic oam_agen_t dualReq(input oam_dual_mode_t m,
			input logic [15:0] base, input logic [15:0] off);
		dualReq.valid = (m != OAM_D_NONE);
		dualReq.addr = (m == OAM_D_INDEXED) ? base + off : base;
	endfunction : dualReq

	assign accept = instr.valid && ready_r;

	// Read ports: the pointer pair bit can only name registers 8 to 11
	always_comb begin
		rdAddrA = instr.srcReg;
		rdAddrB = instr.dstReg;
		rdAddrC = instr.offReg; // One shared offset field
		if (isDual(instr.cls)) begin
			rdAddrA = `OAM_REG_X_PAIR | {3'h0, instr.xSel};
			rdAddrB = `OAM_REG_Y_PAIR | {3'h0, instr.ySel};
		end else if (instr.cls == OAM_C_FRAME_UNLINK) begin
			rdAddrA = `OAM_REG_FRAME;
		end
	end

	oam_wreg_file #(
		.DW(DW),
		.AW(AW)
	) u_wregs (
		.clk_sys(clk_sys),
		.reset(reset),
		.rdAddrA(rdAddrA),
		.rdAddrB(rdAddrB),
		.rdAddrC(rdAddrC),
		.rdDataA(baseA),
		.rdDataB(baseB),
		.rdDataC(offVal),
		.wrEnA(wrEnA),
		.wrAddrA(wrAddrA),
		.wrDataA(wrDataA),
		.wrEnB(wrEnB),
		.wrAddrB(wrAddrB),
		.wrDataB(wrDataB)
	);

	// Decode, address generation and pointer write-back
	always_comb begin
		logic bad;
		logic dual;
		bad = 1'b0;
		dual = isDual(instr_r.cls);
		state_nxt = state_r;
		instr_nxt = instr_r;
		ready_nxt = ready_r;
		result_nxt = result_r;
		result_nxt.done = 1'b0;
		// Outside work the port B write path belongs to the core
		wrEnA = 1'b0;
		wrAddrA = instr_r.srcReg;
		wrDataA = '0;
		wrEnB = wrReq.en && ready_r;
		wrAddrB = wrReq.idx;
		wrDataB = wrReq.data;
		unique case (state_r)
			OAM_S_IDLE: begin
				// Idle always offers ready, so it rises one edge after reset
				ready_nxt = 1'b1;
				if (accept) begin
					instr_nxt = instr;
					state_nxt = OAM_S_EXEC;
					ready_nxt = 1'b0;
				end
			end
			OAM_S_EXEC: begin
				result_nxt = '0;
				result_nxt.done = 1'b1;
				state_nxt = OAM_S_IDLE;
				ready_nxt = 1'b1;
				if (dual) begin
					// Indexed only through the second register of each pair
					if ((instr_r.xMode == OAM_D_INDEXED && !instr_r.xSel) ||
							(instr_r.yMode == OAM_D_INDEXED && !instr_r.ySel)) begin
						bad = 1'b1;
					end
					if (!bad) begin
						// X pair to the X unit, Y pair to the Y unit
						result_nxt.xReq = dualReq(instr_r.xMode, baseA, offVal);
						result_nxt.yReq = dualReq(instr_r.yMode, baseB, offVal);
						wrEnA = dualStep(instr_r.xMode) != `OAM_NO_STEP;
						wrAddrA = `OAM_REG_X_PAIR | {3'h0, instr_r.xSel};
						wrDataA = baseA + dualStep(instr_r.xMode);
						wrEnB = dualStep(instr_r.yMode) != `OAM_NO_STEP;
						wrAddrB = `OAM_REG_Y_PAIR | {3'h0, instr_r.ySel};
						wrDataB = baseB + dualStep(instr_r.yMode);
					end
				end else begin
					unique case (instr_r.cls)
						OAM_C_MOVE, OAM_C_ACCUM: begin
							// A literal can be read but never written
							bad = (instr_r.dstMode == OAM_M_LIT8) ||
								(instr_r.dstMode == OAM_M_LIT16);
							if (!bad) begin
								// Each side keeps its own mode
								result_nxt.src = operandOf(instr_r.srcMode,
									instr_r.srcReg, baseA, offVal, instr_r.lit);
								result_nxt.dst = operandOf(instr_r.dstMode,
									instr_r.dstReg, baseB, offVal, instr_r.lit);
								wrEnA = modifies(instr_r.srcMode);
								wrAddrA = instr_r.srcReg;
								wrDataA = pointerNext(instr_r.srcMode, baseA);
								// Same register both sides: destination wins
								wrEnB = modifies(instr_r.dstMode);
								wrAddrB = instr_r.dstReg;
								wrDataB = pointerNext(instr_r.dstMode, baseB);
							end
						end
						OAM_C_BRANCH: begin
							result_nxt.branchDisp = instr_r.lit;
						end
						OAM_C_INT_DISABLE: begin
							result_nxt.intOffCount =
								instr_r.lit[`OAM_INT_OFF_W-1:0];
						end
						OAM_C_FRAME_UNLINK: begin
							// Stack takes the frame pointer value
							result_nxt.hasImplied = 1'b1;
							result_nxt.impliedSrc = `OAM_REG_FRAME;
							result_nxt.impliedDst = `OAM_REG_STACK;
							result_nxt.src.isReg = 1'b1;
							result_nxt.src.regIdx = `OAM_REG_FRAME;
							result_nxt.src.value = baseA;
							wrEnA = 1'b1;
							wrAddrA = `OAM_REG_STACK;
							wrDataA = baseA;
						end
						OAM_C_NO_OPERATION: ; // No operands at all
						default: bad = 1'b1;
					endcase
				end
				result_nxt.illegal = bad;
			end
		endcase
	end

	// State registers
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_r <= OAM_S_IDLE;
			instr_r <= '0;
			result_r <= '0;
			ready_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			instr_r <= instr_nxt;
			result_r <= result_nxt;
			ready_r <= ready_nxt;
		end
	end

	assign ready = ready_r;
	assign result = result_r;
endmodule : oam_decoder

/* File: core/oam_map.svh */
/*
 Named constants for the operand address decoder: register numbers,
 pointer steps and literal field widths.
 Assumes word-addressed pointers move by two bytes per word.
*/
`ifndef OAM_MAP_SVH
`define OAM_MAP_SVH

// Prefetch pointer registers; low bit picks the member of the pair
`define OAM_REG_X_PAIR 4'h8
`define OAM_REG_Y_PAIR 4'ha
// Registers implied by the frame unlink opcode
`define OAM_REG_FRAME 4'he
`define OAM_REG_STACK 4'hf
// Pointer steps in bytes
`define OAM_WORD_STEP 16'h0002
`define OAM_DUAL_STEP2 16'h0002
`define OAM_DUAL_STEP4 16'h0004
`define OAM_DUAL_STEP6 16'h0006
`define OAM_NO_STEP 16'h0000
// Literal field widths
`define OAM_LIT8_W 8
`define OAM_INT_OFF_W 14

`endif

/* File: core/oam_pkg.sv */
/*
 Types shared by the operand address decoder, its checker and its bench.
 Assumes a 16-bit data path and sixteen working registers.
*/
package oam_pkg;

	typedef enum logic [3:0] {
		OAM_C_NO_OPERATION, OAM_C_MOVE, OAM_C_ACCUM, OAM_C_ACC_CLEAR,
		OAM_C_EUCLID, OAM_C_DIST_ACCUM, OAM_C_MULT_ACCUM, OAM_C_MULTIPLY,
		OAM_C_NEG_MULTIPLY, OAM_C_STORE_ACC, OAM_C_MULT_SUB,
		OAM_C_BRANCH, OAM_C_INT_DISABLE, OAM_C_FRAME_UNLINK
	} oam_class_t;

	typedef enum logic [3:0] {
		OAM_M_REG_DIRECT, OAM_M_INDIRECT, OAM_M_POST_INC, OAM_M_POST_DEC,
		OAM_M_PRE_INC, OAM_M_PRE_DEC, OAM_M_INDEXED, OAM_M_LIT_OFFSET,
		OAM_M_LIT8, OAM_M_LIT16
	} oam_mode_t;

	typedef enum logic [2:0] {
		OAM_D_NONE, OAM_D_INDIRECT, OAM_D_POST2, OAM_D_POST4, OAM_D_POST6,
		OAM_D_INDEXED
	} oam_dual_mode_t;

	typedef enum logic {OAM_S_IDLE, OAM_S_EXEC} oam_state_t;

	typedef struct packed {
		logic valid;
		oam_class_t cls;
		oam_mode_t srcMode;
		oam_mode_t dstMode;
		logic [3:0] srcReg;
		logic [3:0] dstReg;
		logic [3:0] offReg;
		logic xSel;
		logic ySel;
		oam_dual_mode_t xMode;
		oam_dual_mode_t yMode;
		logic [15:0] lit;
	} oam_instr_t;

	typedef struct packed {
		logic en;
		logic [3:0] idx;
		logic [15:0] data;
	} oam_wreq_t;

	typedef struct packed {
		logic used;
		logic isReg;
		logic isLit;
		logic [3:0] regIdx;
		logic [15:0] value;
	} oam_operand_t;

	typedef struct packed {
		logic valid;
		logic [15:0] addr;
	} oam_agen_t;

	typedef struct packed {
		logic done;
		logic illegal;
		oam_operand_t src;
		oam_operand_t dst;
		oam_agen_t xReq;
		oam_agen_t yReq;
		logic [15:0] branchDisp;
		logic [13:0] intOffCount;
		logic hasImplied;
		logic [3:0] impliedSrc;
		logic [3:0] impliedDst;
	} oam_result_t;

endpackage : oam_pkg

/* File: core/oam_wreg_file.sv */
/*
 Working register file: three registered read ports, two write ports.
 Assumes the caller never reads and writes one entry in the same cycle
 when it needs the new value; reads return the old contents.
*/
`timescale 1ns/1ps
module oam_wreg_file #(
	parameter int DW = 16,
	parameter int AW = 4
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [AW-1:0] rdAddrA,
	input wire logic [AW-1:0] rdAddrB,
	input wire logic [AW-1:0] rdAddrC,
	output logic [DW-1:0] rdDataA,
	output logic [DW-1:0] rdDataB,
	output logic [DW-1:0] rdDataC,
	input wire logic wrEnA,
	input wire logic [AW-1:0] wrAddrA,
	input wire logic [DW-1:0] wrDataA,
	input wire logic wrEnB,
	input wire logic [AW-1:0] wrAddrB,
	input wire logic [DW-1:0] wrDataB
);
	logic [DW-1:0] mem [2**AW];

	// Port B is written last so it wins when both hit one entry
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			for (int i = 0; i < 2**AW; i++) begin
				mem[i] <= '0;
			end
			rdDataA <= '0;
			rdDataB <= '0;
			rdDataC <= '0;
		end else begin
			if (wrEnA) begin
				mem[wrAddrA] <= wrDataA;
			end
			if (wrEnB) begin
				mem[wrAddrB] <= wrDataB;
			end
			rdDataA <= mem[rdAddrA];
			rdDataB <= mem[rdAddrB];
			rdDataC <= mem[rdAddrC];
		end
	end
endmodule : oam_wreg_file

/* File: test/oam_decoder_asserts.sv */
/*
 Port checker for the operand address decoder.
 Assumes it is bound to oam_decoder and sees one clock domain.
*/
`timescale 1ns/1ps
module oam_decoder_asserts
	import oam_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire oam_instr_t instr,
	input wire oam_wreq_t wrReq,
	input wire logic ready,
	input wire oam_result_t result
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	// Dual classes form one run of the class enum
	logic isDual;
	assign isDual = instr.cls inside {[OAM_C_ACC_CLEAR:OAM_C_MULT_SUB]};
	sequence taken;
		instr.valid && ready;
	endsequence
	sequence takenAs(oam_class_t c);
		instr.valid && ready && instr.cls == c;
	endsequence
	sequence answer;
		!ready ##1 (ready && result.done);
	endsequence
	AST_LATENCY: assert property (taken |=> answer)
		else $error("result not two edges after take");
	AST_BRANCH: assert property (takenAs(OAM_C_BRANCH) |-> ##2
		result.branchDisp == $past(instr.lit, 2))
		else $error("branch displacement wrong");
	AST_INT_OFF: assert property (takenAs(OAM_C_INT_DISABLE) |-> ##2
		result.intOffCount == $past(instr.lit[13:0], 2))
		else $error("disable count wrong");
	AST_NO_OP: assert property (takenAs(OAM_C_NO_OPERATION) |-> ##2
		!(result.src.used || result.src.isReg || result.src.isLit ||
		result.dst.used || result.xReq.valid || result.yReq.valid))
		else $error("no-op shows an operand");
	AST_UNLINK: assert property (takenAs(OAM_C_FRAME_UNLINK) |-> ##2
		result.hasImplied && result.impliedSrc == 4'he &&
		result.impliedDst == 4'hf)
		else $error("unlink implied registers wrong");
	AST_X_INDEXED: assert property (taken ##0 (isDual &&
		instr.xMode == OAM_D_INDEXED && !instr.xSel) |-> ##2
		result.illegal && !result.xReq.valid)
		else $error("indexed X prefetch on wrong register");
	AST_Y_INDEXED: assert property (taken ##0 (isDual &&
		instr.yMode == OAM_D_INDEXED && !instr.ySel) |-> ##2
		result.illegal && !result.yReq.valid)
		else $error("indexed Y prefetch on wrong register");
	AST_DST_LIT: assert property (taken ##0 (instr.cls inside
		{OAM_C_MOVE, OAM_C_ACCUM} && instr.dstMode inside
		{OAM_M_LIT8, OAM_M_LIT16}) |-> ##2 result.illegal)
		else $error("literal destination accepted");
	AST_NO_Y: assert property (taken ##0 (isDual &&
		instr.yMode == OAM_D_NONE) |-> ##2 !result.yReq.valid)
		else $error("Y request without Y pointer");
	AST_X_REQ: assert property (taken ##0 (isDual &&
		instr.xMode == OAM_D_POST2 && instr.yMode != OAM_D_INDEXED)
		|-> ##2 result.xReq.valid && !result.illegal)
		else $error("X request missing");
endmodule : oam_decoder_asserts

/* File: test/test_operand_address_modes.sv */
/*
 Self-checking bench for the operand address decoder.
 Assumes the decoder answers two edges after taking an instruction.
*/
`timescale 1ns/1ps
module test_operand_address_modes
	import oam_pkg::*;
;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	oam_instr_t instr = '0;
	oam_wreq_t wrReq = '0;
	logic ready;
	oam_result_t result;
	oam_result_t res;
	int failCount = 0;
	int cmpCount = 0;
	typedef struct packed {
		oam_instr_t in;
		logic [1:0] sk;
		logic [15:0] sv;
		logic [1:0] dk;
		logic [15:0] dv;
		logic [33:0] xy;
		logic ill;
	} oam_row_t;
	oam_row_t rows[$];
	localparam logic [1:0] kNone = 2'h0, kReg = 2'h1, kMem = 2'h2, kLit = 2'h3;
	always #10 clk_sys = ~clk_sys;
	oam_decoder u_dut (.clk_sys(clk_sys), .reset(reset), .instr(instr),
		.wrReq(wrReq), .ready(ready), .result(result));
	task automatic closeOut;
		$display("compares %0d mismatches %0d", cmpCount, failCount);
		if (failCount == 0 && cmpCount > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : closeOut
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		cmpCount++;
		if (g !== e) begin
			failCount++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic chkOp(string nm, logic [1:0] k, logic [15:0] v,
		oam_operand_t o);
		chk(nm, {13'h0, k == kMem, k == kReg, k == kLit},
			{13'h0, o.used, o.isReg, o.isLit});
		if (k != kNone) chk(nm, v, o.value);
	endtask : chkOp
	task automatic chkAg(string nm, logic [16:0] e, oam_agen_t g);
		chk(nm, {15'h0, e[16]}, {15'h0, g.valid});
		if (e[16]) chk(nm, e[15:0], g.addr);
	endtask : chkAg
	// Bounded wait so a stuck decoder ends the run instead of hanging it
	task automatic waitReady;
		for (int n = 0; ready !== 1'b1; n++) begin
			if (n > 20) begin
				chk("ready", 16'h1, {15'h0, ready});
				closeOut();
			end else begin
				@(posedge clk_sys);
				#1;
			end
		end
	endtask : waitReady
	// Register i holds i*16: prefetch pointers stay in their space
	task automatic preload;
		waitReady();
		for (int i = 0; i < 16; i++) begin
			wrReq = '{1'b1, i[3:0], {i[11:0], 4'h0}};
			@(posedge clk_sys);
			#1;
		end
		wrReq = '0;
	endtask : preload
	task automatic issue(oam_instr_t i);
		waitReady();
		instr = i;
		@(posedge clk_sys);
		#1;
		instr = '0;
		@(posedge clk_sys);
		#1;
		chk("done", 16'h1, {15'h0, result.done});
		res = result;
	endtask : issue
	// Move rows use source 5, destination 6, offset register 2
	function automatic oam_instr_t mi(oam_class_t c, oam_mode_t s,
		oam_mode_t d, logic [15:0] lit);
		mi = '0;
		mi.valid = 1'b1;
		mi.cls = c;
		mi.srcMode = s;
		mi.dstMode = d;
		mi.srcReg = 4'h5;
		mi.dstReg = 4'h6;
		mi.offReg = 4'h2;
		mi.lit = lit;
	endfunction : mi
	function automatic oam_instr_t di(oam_class_t c, oam_dual_mode_t xm,
		logic xs, oam_dual_mode_t ym, logic ys);
		di = '0;
		di.valid = 1'b1;
		di.cls = c;
		di.xMode = xm;
		di.xSel = xs; // Pair select can only name 8 to 11
		di.yMode = ym;
		di.ySel = ys;
		di.offReg = 4'h2;
	endfunction : di
	task automatic addM(oam_instr_t i, logic [1:0] sk, logic [15:0] sv,
		logic [1:0] dk, logic [15:0] dv);
		rows.push_back('{i, sk, sv, dk, dv, 34'h0, sk == kNone});
	endtask : addM
	task automatic addD(oam_instr_t i, logic [33:0] xy, logic ill);
		rows.push_back('{i, kNone, 16'h0, kNone, 16'h0, xy, ill});
	endtask : addD
	initial begin
		addM(mi(OAM_C_MOVE, OAM_M_REG_DIRECT, OAM_M_INDIRECT, 16'h0),
			kReg, 16'h0050, kMem, 16'h0060);
		addM(mi(OAM_C_MOVE, OAM_M_POST_INC, OAM_M_PRE_DEC, 16'h0),
			kMem, 16'h0050, kMem, 16'h005e);
		addM(mi(OAM_C_MOVE, OAM_M_INDEXED, OAM_M_POST_DEC, 16'h0),
			kMem, 16'h0070, kMem, 16'h0060);
		addM(mi(OAM_C_MOVE, OAM_M_LIT_OFFSET, OAM_M_INDEXED, 16'h6),
			kMem, 16'h0056, kMem, 16'h0080);
		addM(mi(OAM_C_ACCUM, OAM_M_LIT8, OAM_M_PRE_INC, 16'h12ab),
			kLit, 16'h00ab, kMem, 16'h0062);
		addM(mi(OAM_C_ACCUM, OAM_M_LIT16, OAM_M_REG_DIRECT, 16'h12ab),
			kLit, 16'h12ab, kReg, 16'h0060);
		addM(mi(OAM_C_MOVE, OAM_M_INDIRECT, OAM_M_LIT16, 16'h1),
			kNone, 16'h0, kNone, 16'h0);
		addD(di(OAM_C_ACC_CLEAR, OAM_D_INDIRECT, 1'b0, OAM_D_POST2, 1'b1),
			{1'b1, 16'h0080, 1'b1, 16'h00b0}, 1'b0);
		addD(di(OAM_C_EUCLID, OAM_D_POST4, 1'b1, OAM_D_POST6, 1'b0),
			{1'b1, 16'h0090, 1'b1, 16'h00a0}, 1'b0);
		addD(di(OAM_C_DIST_ACCUM, OAM_D_INDEXED, 1'b1, OAM_D_NONE, 1'b0),
			{1'b1, 16'h00b0, 17'h0}, 1'b0);
		addD(di(OAM_C_MULT_ACCUM, OAM_D_NONE, 1'b0, OAM_D_INDEXED, 1'b1),
			{17'h0, 1'b1, 16'h00d0}, 1'b0);
		addD(di(OAM_C_MULTIPLY, OAM_D_INDEXED, 1'b0, OAM_D_POST2, 1'b1),
			34'h0, 1'b1);
		addD(di(OAM_C_NEG_MULTIPLY, OAM_D_POST2, 1'b1, OAM_D_INDEXED, 1'b0),
			34'h0, 1'b1);
		addD(di(OAM_C_STORE_ACC, OAM_D_POST2, 1'b0, OAM_D_NONE, 1'b1),
			{1'b1, 16'h0080, 17'h0}, 1'b0);
		addD(di(OAM_C_MULT_SUB, OAM_D_NONE, 1'b1, OAM_D_POST4, 1'b0),
			{17'h0, 1'b1, 16'h00a0}, 1'b0);
		repeat (12) @(posedge clk_sys);
		#1;
		chk("ready in reset", 16'h0, {15'h0, ready});
		chk("result in reset", 16'h0, {15'h0, result !== '0});
		reset = 1'b0;
		@(posedge clk_sys);
		#1;
		chk("ready after reset", 16'h1, {15'h0, ready});
		$display("test reset finished");
		foreach (rows[n]) begin
			preload();
			issue(rows[n].in);
			chkOp("src", rows[n].sk, rows[n].sv, res.src);
			chkOp("dst", rows[n].dk, rows[n].dv, res.dst);
			chkAg("x", rows[n].xy[33:17], res.xReq);
			chkAg("y", rows[n].xy[16:0], res.yReq);
			chk("illegal", {15'h0, rows[n].ill}, {15'h0, res.illegal});
		end
		$display("test table finished");
		// Pointer write-back must reach the very next instruction
		preload();
		issue(mi(OAM_C_MOVE, OAM_M_INDEXED, OAM_M_PRE_DEC, 16'h0));
		issue(mi(OAM_C_MOVE, OAM_M_INDIRECT, OAM_M_INDIRECT, 16'h0));
		chkOp("base kept", kMem, 16'h0050, res.src);
		chkOp("pre dec", kMem, 16'h005e, res.dst);
		issue(di(OAM_C_MULT_ACCUM, OAM_D_POST6, 1'b1, OAM_D_INDEXED, 1'b1));
		issue(di(OAM_C_MULT_ACCUM, OAM_D_POST2, 1'b1, OAM_D_POST2, 1'b1));
		chkAg("x post6", {1'b1, 16'h0096}, res.xReq);
		chkAg("y base", {1'b1, 16'h00b0}, res.yReq);
		$display("test write-back finished");
		// Held valid: one take every second edge; busy write ignored
		instr = mi(OAM_C_MOVE, OAM_M_POST_INC, OAM_M_REG_DIRECT, 16'h0);
		@(posedge clk_sys);
		#1;
		wrReq = '{1'b1, 4'h6, 16'hdead};
		@(posedge clk_sys);
		#1;
		wrReq = '0;
		chkOp("first", kMem, 16'h0050, result.src);
		@(posedge clk_sys);
		#1;
		instr = '0;
		@(posedge clk_sys);
		#1;
		chkOp("second", kMem, 16'h0052, result.src);
		chkOp("busy write", kReg, 16'h005e, result.dst);
		$display("test back-to-back finished");
		issue(mi(OAM_C_BRANCH, OAM_M_REG_DIRECT, OAM_M_REG_DIRECT, 16'h8001));
		chk("branch", 16'h8001, res.branchDisp);
		issue(mi(OAM_C_INT_DISABLE, OAM_M_REG_DIRECT, OAM_M_REG_DIRECT,
			16'hffff));
		chk("disable", 16'h3fff, {2'h0, res.intOffCount});
		issue(mi(OAM_C_NO_OPERATION, OAM_M_INDIRECT, OAM_M_INDIRECT, 16'h0));
		chkOp("no-op", kNone, 16'h0, res.src);
		issue(mi(OAM_C_FRAME_UNLINK, OAM_M_REG_DIRECT, OAM_M_REG_DIRECT,
			16'h0));
		chk("unlink", 16'h1ef, {7'h0, res.hasImplied, res.impliedSrc,
			res.impliedDst});
		chkOp("unlink src", kReg, 16'h00e0, res.src);
		$display("test literals finished");
		closeOut();
	end
endmodule : test_operand_address_modes

bind oam_decoder oam_decoder_asserts u_chk (.clk_sys(clk_sys),
	.reset(reset), .instr(instr), .wrReq(wrReq), .ready(ready),
	.result(result));
